//--- logic/mwfc_pkg.sv
// Constants and carrier types for the MMU walker, fault capture and cache block
package mwfc_pkg;
	// ************************************************************
	// Sizes
	// ************************************************************
	localparam int WAYS = 4;
	localparam int SETS = 128;
	localparam int TLBN = 4;
	// ************************************************************
	// Register byte offsets
	// ************************************************************
	localparam logic [5:0] A_CTRL = 6'h04;
	localparam logic [5:0] A_TTB = 6'h08;
	localparam logic [5:0] A_DOM = 6'h0c;
	localparam logic [5:0] A_DFSR = 6'h14;
	localparam logic [5:0] A_FAR = 6'h18;
	localparam logic [5:0] A_COP = 6'h1c;
	localparam logic [5:0] A_LOCK = 6'h24;
	localparam logic [5:0] A_IFSR = 6'h28;
	localparam logic [5:0] A_IST = 6'h30;
	localparam logic [5:0] A_IMSK = 6'h34;
	localparam logic [31:0] RST0 = 32'h0000_0000;
	// ************************************************************
	// Field positions
	// ************************************************************
	localparam int C_MMU = 0;
	localparam int C_ALN = 1;
	localparam int C_DC = 2;
	localparam int C_IC = 12;
	localparam int OP_INVI = 0;
	localparam int OP_INVD = 1;
	localparam int LK_I = 0;
	localparam int LK_D = 4;
	localparam int IR_DAB = 0;
	localparam int IR_PAB = 1;
	localparam int IR_RFL = 2;
	// ************************************************************
	// Encodings
	// ************************************************************
	localparam logic [3:0] F_ALN = 4'h1;
	localparam logic [3:0] F_TRS = 4'h5;
	localparam logic [3:0] F_TRP = 4'h7;
	localparam logic [3:0] F_DMS = 4'h9;
	localparam logic [3:0] F_DMP = 4'hb;
	localparam logic [3:0] F_PMS = 4'hd;
	localparam logic [3:0] F_PMP = 4'hf;
	localparam logic [1:0] D_FLT = 2'h0;
	localparam logic [1:0] D_CRS = 2'h1;
	localparam logic [1:0] D_SEC = 2'h2;
	localparam logic [1:0] P_LRG = 2'h1;
	localparam logic [1:0] P_SML = 2'h2;
	localparam logic [1:0] ACC_CLI = 2'h1;
	localparam logic [1:0] ACC_MGR = 2'h3;
	localparam logic [1:0] AP_NONE = 2'h0;
	localparam logic [1:0] AP_PRIV = 2'h1;
	localparam logic [1:0] AP_UREAD = 2'h2;
	localparam logic [21:0] MSK_SEC = 22'h3ffc00;
	localparam logic [21:0] MSK_LRG = 22'h3fffc0;
	localparam logic [21:0] MSK_SML = 22'h3ffffc;
	localparam logic [21:0] MSK_TNY = 22'h3fffff;
	localparam logic [1:0] HT_IDLE = 2'h0;
	localparam logic [1:0] HT_NSEQ = 2'h2;
	localparam logic [2:0] HS_WORD = 3'h2;
	localparam logic [2:0] LAST_BEAT = 3'h7;
	typedef enum logic [6:0] {
		ST_IDLE = 7'h01,
		ST_XLAT = 7'h02,
		ST_WLK1 = 7'h04,
		ST_WLK2 = 7'h08,
		ST_RFIL = 7'h10,
		ST_SNGL = 7'h20,
		ST_WBUF = 7'h40
	} mwfc_st_t;
	typedef struct packed {
		logic data;
		logic write;
		logic priv;
		logic [1:0] size;
		logic [31:0] addr;
		logic [31:0] wdata;
	} mwfc_req_t;
	typedef struct packed {
		logic v;
		logic [21:0] va;
		logic [21:0] msk;
		logic [21:0] pa;
		logic [1:0] ap;
		logic [3:0] dom;
		logic c;
		logic pg;
	} mwfc_tlb_t;
endpackage : mwfc_pkg

//--- logic/mwfc_top.sv
// Table walker, fault capture, instruction and data caches with write buffer
`timescale 1ns/100ps
// Overview of operation
// - Walker reads tables in memory and loads address and permissions into the TLB.
// - Walk starts with a first-level fetch; pages need one more fetch.
// - One section size and large, small and tiny page sizes.
// - Abort on translation, domain, permission faults; alignment only for data.
// - A faulting access is cancelled and reported to the core as abort.
// - Data faults keep status and address; fetch faults keep status separately.
// - Fault status holds cause and domain, updated when the abort happens.
// - Fault address holds the address of the latest data abort.
// - Separate instruction and data caches of 16KB plus a data write buffer.
// - Four ways, tagged by modified address, eight-word lines, two dirty bits.
// - Way lockdown, pollution control and victim replacement in each cache.
// - Read miss refill returns the critical word first, then wraps the line.
// - Control, cache operation and lockdown registers steer the caches.
// - Instruction cache enable bit: one enables, zero disables.
// - With translation on, every fetch is translated and checked.
// - With translation off, fetches are cacheable, unchecked, flat mapped.
module mwfc_top (
	input wire logic clock_in,
	input wire logic rst_b_in,
	input wire logic core_req_vld_in,
	input wire mwfc_pkg::mwfc_req_t core_req_in,
	output logic core_busy_out,
	output logic core_done_out,
	output logic core_abort_out,
	output logic [31:0] core_rdata_out,
	input wire logic [5:0] reg_addr_in,
	input wire logic [31:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [31:0] reg_rdata_out,
	output logic [1:0] htrans_out,
	output logic [31:0] haddr_out,
	output logic hwrite_out,
	output logic [2:0] hsize_out,
	output logic [31:0] hwdata_out,
	input wire logic hready_in,
	input wire logic [31:0] hrdata_in,
	output logic irq_out
);
	// ************************************************************
	// State
	// ************************************************************
	mwfc_pkg::mwfc_st_t st_q, st_d;
	mwfc_pkg::mwfc_req_t rq_q, rq_d;
	mwfc_pkg::mwfc_tlb_t tlb_q [mwfc_pkg::TLBN], tlb_d [mwfc_pkg::TLBN], te;
	logic ph_q, ph_d, done_q, done_d, abort_q, abort_d;
	logic [31:0] pa_q, pa_d, l1_q, l1_d, hwd_q, hwd_d, rdat_q, rdat_d, rdo_q, rdo_d;
	logic [31:0] ctrl_q, ctrl_d, ttb_q, ttb_d, dom_q, dom_d, far_q, far_d;
	logic [7:0] dfsr_q, dfsr_d, ifsr_q, ifsr_d, lock_q, lock_d;
	logic [2:0] ist_q, ist_d, imsk_q, imsk_d, bt_q, bt_d;
	logic [1:0] way_q, way_d, tp_q, tp_d;
	logic [1:0] rr_q [2], rr_d [2];
	logic [mwfc_pkg::WAYS-1:0] val_q [2][mwfc_pkg::SETS], val_d [2][mwfc_pkg::SETS];
	logic [7:0] dty_q [mwfc_pkg::SETS], dty_d [mwfc_pkg::SETS];
	logic [19:0] tag_mem [2][mwfc_pkg::WAYS][mwfc_pkg::SETS];
	logic [31:0] dat_mem [2][mwfc_pkg::WAYS][mwfc_pkg::SETS*8];
	// ************************************************************
	// Combinational helpers
	// ************************************************************
	logic cs, cen, thit, flt, ccb, ab, tf, tpg, tw_en, dw_en;
	logic [6:0] set;
	logic [2:0] wd;
	logic [3:0] chit, lk, ben, fcode, fdom, ac, ad, tdm;
	logic [mwfc_pkg::TLBN-1:0] hitv;
	logic [1:0] hway, vict, acc, tap, wj;
	logic [21:0] tm;
	logic [31:0] cdat, mrg, dw_dat, d;
	logic [9:0] dw_idx;
	logic [2:0] clr;
	assign cs = rq_q.data;
	assign set = rq_q.addr[11:5];
	assign wd = rq_q.addr[4:2];
	assign cen = cs ? ctrl_q[mwfc_pkg::C_DC] : ctrl_q[mwfc_pkg::C_IC];
	assign lk = cs ? lock_q[mwfc_pkg::LK_D +: 4] : lock_q[mwfc_pkg::LK_I +: 4];
	assign thit = |hitv;
	for (genvar w = 0; w < mwfc_pkg::WAYS; w++) begin : g_way
		assign chit[w] = val_q[cs][set][w] && tag_mem[cs][w][set] == rq_q.addr[31:12];
	end
	for (genvar t = 0; t < mwfc_pkg::TLBN; t++) begin : g_tlb
		assign hitv[t] = tlb_q[t].v && ((rq_q.addr[31:10] ^ tlb_q[t].va) & tlb_q[t].msk) == '0;
	end
	always_comb begin
		cdat = '0;
		hway = '0;
		te = '0;
		vict = rr_q[cs];
		for (int w = 0; w < mwfc_pkg::WAYS; w++) begin
			if (chit[w]) begin
				cdat = dat_mem[cs][w][{set, wd}];
				hway = 2'(w);
			end
		end
		for (int t = 0; t < mwfc_pkg::TLBN; t++) begin
			if (hitv[t]) begin
				te = tlb_q[t];
			end
		end
		// Round-robin victim that skips locked ways
		for (int i = mwfc_pkg::WAYS - 1; i >= 0; i--) begin
			wj = rr_q[cs] + 2'(i);
			if (!lk[wj]) begin
				vict = wj;
			end
		end
		case (rq_q.size)
			2'h0: ben = 4'h1 << rq_q.addr[1:0];
			2'h1: ben = 4'h3 << rq_q.addr[1:0];
			default: ben = 4'hf;
		endcase
		for (int b = 0; b < 4; b++) begin
			mrg[8*b +: 8] = ben[b] ? rq_q.wdata[8*b +: 8] : cdat[8*b +: 8];
		end
	end
	// ************************************************************
	// Access checks
	// ************************************************************
	always_comb begin
		flt = 1'b0;
		fcode = '0;
		fdom = '0;
		acc = dom_q[{te.dom, 1'b0} +: 2];
		if (rq_q.data && ctrl_q[mwfc_pkg::C_ALN] &&
			(rq_q.size == 2'h2 ? |rq_q.addr[1:0] : rq_q.size == 2'h1 && rq_q.addr[0])) begin
			flt = 1'b1;
			fcode = mwfc_pkg::F_ALN;
		end else if (ctrl_q[mwfc_pkg::C_MMU] && thit) begin
			fdom = te.dom;
			if (acc != mwfc_pkg::ACC_CLI && acc != mwfc_pkg::ACC_MGR) begin
				flt = 1'b1;
				fcode = te.pg ? mwfc_pkg::F_DMP : mwfc_pkg::F_DMS;
			end else if (acc == mwfc_pkg::ACC_CLI && (te.ap == mwfc_pkg::AP_NONE ||
				(te.ap == mwfc_pkg::AP_PRIV && !rq_q.priv) ||
				(te.ap == mwfc_pkg::AP_UREAD && !rq_q.priv && rq_q.write))) begin
				flt = 1'b1;
				fcode = te.pg ? mwfc_pkg::F_PMP : mwfc_pkg::F_PMS;
			end
		end
	end
	// ************************************************************
	// Next state
	// ************************************************************
	always_comb begin
		st_d = st_q; rq_d = rq_q; tlb_d = tlb_q; ph_d = ph_q;
		pa_d = pa_q; l1_d = l1_q; hwd_d = hwd_q; rdat_d = rdat_q;
		ctrl_d = ctrl_q; ttb_d = ttb_q; dom_d = dom_q; far_d = far_q;
		dfsr_d = dfsr_q; ifsr_d = ifsr_q; lock_d = lock_q; imsk_d = imsk_q;
		bt_d = bt_q; way_d = way_q; tp_d = tp_q; rr_d = rr_q;
		val_d = val_q; dty_d = dty_q;
		done_d = 1'b0; abort_d = 1'b0; rdo_d = '0; clr = '0; ist_d = ist_q;
		ab = 1'b0; ac = '0; ad = '0; tf = 1'b0; tm = '0; tap = '0; tdm = '0; tpg = 1'b0;
		tw_en = 1'b0; dw_en = 1'b0; dw_dat = '0; dw_idx = '0; ccb = 1'b0; d = hrdata_in;
		if (reg_wr_in) begin
			case (reg_addr_in)
				mwfc_pkg::A_CTRL: ctrl_d = reg_wdata_in;
				mwfc_pkg::A_TTB: ttb_d = reg_wdata_in;
				mwfc_pkg::A_DOM: dom_d = reg_wdata_in;
				mwfc_pkg::A_DFSR: dfsr_d = reg_wdata_in[7:0];
				mwfc_pkg::A_FAR: far_d = reg_wdata_in;
				mwfc_pkg::A_COP: begin
					for (int s = 0; s < mwfc_pkg::SETS; s++) begin
						if (reg_wdata_in[mwfc_pkg::OP_INVI]) begin
							val_d[0][s] = '0;
						end
						if (reg_wdata_in[mwfc_pkg::OP_INVD]) begin
							val_d[1][s] = '0;
						end
					end
				end
				mwfc_pkg::A_LOCK: lock_d = reg_wdata_in[7:0];
				mwfc_pkg::A_IFSR: ifsr_d = reg_wdata_in[7:0];
				mwfc_pkg::A_IST: clr = reg_wdata_in[2:0];
				mwfc_pkg::A_IMSK: imsk_d = reg_wdata_in[2:0];
				default: ;
			endcase
		end
		// Clear first, so that an event later in this cycle sets its bit again
		ist_d = ist_q & ~clr;
		if (reg_rd_in) begin
			case (reg_addr_in)
				mwfc_pkg::A_CTRL: rdo_d = ctrl_q;
				mwfc_pkg::A_TTB: rdo_d = ttb_q;
				mwfc_pkg::A_DOM: rdo_d = dom_q;
				mwfc_pkg::A_DFSR: rdo_d = {24'h000000, dfsr_q};
				mwfc_pkg::A_FAR: rdo_d = far_q;
				mwfc_pkg::A_LOCK: rdo_d = {24'h000000, lock_q};
				mwfc_pkg::A_IFSR: rdo_d = {24'h000000, ifsr_q};
				mwfc_pkg::A_IST: rdo_d = {29'h00000000, ist_q};
				mwfc_pkg::A_IMSK: rdo_d = {29'h00000000, imsk_q};
				default: rdo_d = '0;
			endcase
		end
		case (st_q)
			mwfc_pkg::ST_IDLE: begin
				if (core_req_vld_in) begin
					rq_d = core_req_in;
					st_d = mwfc_pkg::ST_XLAT;
				end
			end
			mwfc_pkg::ST_XLAT: begin
				ph_d = 1'b0;
				if (flt) begin
					ab = 1'b1;
					ac = fcode;
					ad = fdom;
				end else if (ctrl_q[mwfc_pkg::C_MMU] && !thit) begin
					pa_d = {ttb_q[31:14], rq_q.addr[31:20], 2'b00};
					st_d = mwfc_pkg::ST_WLK1;
				end else begin
					if (ctrl_q[mwfc_pkg::C_MMU]) begin
						pa_d = {(te.pa & te.msk) | (rq_q.addr[31:10] & ~te.msk), rq_q.addr[9:0]};
						ccb = te.c;
					end else begin
						pa_d = rq_q.addr;
						ccb = !rq_q.data;
					end
					if (rq_q.write) begin
						// Posted write: the core moves on while the buffer drains
						hwd_d = rq_q.wdata;
						done_d = 1'b1;
						st_d = mwfc_pkg::ST_WBUF;
						if (|chit) begin
							dw_en = 1'b1;
							dw_idx = {set, wd};
							dw_dat = mrg;
							dty_d[set][{hway, rq_q.addr[4]}] = 1'b1;
						end
					end else if (ccb && cen && |chit) begin
						rdat_d = cdat;
						done_d = 1'b1;
						st_d = mwfc_pkg::ST_IDLE;
					end else if (ccb && cen && lk != 4'hf) begin
						way_d = vict;
						val_d[cs][set][vict] = 1'b0;
						bt_d = '0;
						st_d = mwfc_pkg::ST_RFIL;
					end else begin
						// Not cacheable, cache disabled or all ways locked: read around the cache
						st_d = mwfc_pkg::ST_SNGL;
					end
				end
			end
			mwfc_pkg::ST_WLK1: begin
				if (!ph_q) begin
					ph_d = hready_in;
				end else if (hready_in) begin
					ph_d = 1'b0;
					l1_d = d;
					case (d[1:0])
						mwfc_pkg::D_FLT: begin
							ab = 1'b1;
							ac = mwfc_pkg::F_TRS;
						end
						mwfc_pkg::D_SEC: begin
							tf = 1'b1;
							tm = mwfc_pkg::MSK_SEC;
							tap = d[11:10];
							tdm = d[8:5];
						end
						mwfc_pkg::D_CRS: begin
							pa_d = {d[31:10], rq_q.addr[19:12], 2'b00};
							st_d = mwfc_pkg::ST_WLK2;
						end
						default: begin
							pa_d = {d[31:12], rq_q.addr[19:10], 2'b00};
							st_d = mwfc_pkg::ST_WLK2;
						end
					endcase
				end
			end
			mwfc_pkg::ST_WLK2: begin
				if (!ph_q) begin
					ph_d = hready_in;
				end else if (hready_in) begin
					ph_d = 1'b0;
					tap = d[5:4];
					tdm = l1_q[8:5];
					tpg = 1'b1;
					tf = d[1:0] != mwfc_pkg::D_FLT;
					case (d[1:0])
						mwfc_pkg::D_FLT: begin
							ab = 1'b1;
							ac = mwfc_pkg::F_TRP;
							ad = l1_q[8:5];
						end
						mwfc_pkg::P_LRG: tm = mwfc_pkg::MSK_LRG;
						mwfc_pkg::P_SML: tm = mwfc_pkg::MSK_SML;
						default: tm = mwfc_pkg::MSK_TNY;
					endcase
				end
			end
			mwfc_pkg::ST_RFIL: begin
				if (!ph_q) begin
					ph_d = hready_in;
				end else if (hready_in) begin
					ph_d = 1'b0;
					dw_en = 1'b1;
					dw_idx = {set, pa_q[4:2]};
					dw_dat = d;
					if (bt_q == '0) begin
						rdat_d = d;
						done_d = 1'b1;
					end
					if (bt_q == mwfc_pkg::LAST_BEAT) begin
						tw_en = 1'b1;
						val_d[cs][set][way_q] = 1'b1;
						dty_d[set][{way_q, 1'b0} +: 2] = '0;
						rr_d[cs] = way_q + 2'h1;
						ist_d[mwfc_pkg::IR_RFL] = 1'b1;
						st_d = mwfc_pkg::ST_IDLE;
					end else begin
						bt_d = bt_q + 3'h1;
						pa_d[4:2] = pa_q[4:2] + 3'h1;
					end
				end
			end
			default: begin
				if (!ph_q) begin
					ph_d = hready_in;
				end else if (hready_in) begin
					ph_d = 1'b0;
					if (st_q == mwfc_pkg::ST_SNGL) begin
						rdat_d = d;
						done_d = 1'b1;
					end
					st_d = mwfc_pkg::ST_IDLE;
				end
			end
		endcase
		if (tf) begin
			tlb_d[tp_q] = '{1'b1, rq_q.addr[31:10], tm, d[31:10], tap, tdm, d[3], tpg};
			tp_d = tp_q + 2'h1;
			st_d = mwfc_pkg::ST_XLAT;
		end
		if (ab) begin
			done_d = 1'b1;
			abort_d = 1'b1;
			st_d = mwfc_pkg::ST_IDLE;
			if (rq_q.data) begin
				dfsr_d = {ad, ac};
				far_d = rq_q.addr;
				ist_d[mwfc_pkg::IR_DAB] = 1'b1;
			end else begin
				ifsr_d = {ad, ac};
				ist_d[mwfc_pkg::IR_PAB] = 1'b1;
			end
		end
	end
	// ************************************************************
	// Registers and arrays
	// ************************************************************
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			st_q <= mwfc_pkg::ST_IDLE; rq_q <= '0; tlb_q <= '{default: '0}; ph_q <= 1'b0;
			pa_q <= mwfc_pkg::RST0; l1_q <= mwfc_pkg::RST0; hwd_q <= mwfc_pkg::RST0;
			rdat_q <= mwfc_pkg::RST0; rdo_q <= mwfc_pkg::RST0; ctrl_q <= mwfc_pkg::RST0;
			ttb_q <= mwfc_pkg::RST0; dom_q <= mwfc_pkg::RST0; far_q <= mwfc_pkg::RST0;
			dfsr_q <= '0; ifsr_q <= '0; lock_q <= '0; ist_q <= '0; imsk_q <= '0;
			bt_q <= '0; way_q <= '0; tp_q <= '0; rr_q <= '{default: '0};
			val_q <= '{default: '0}; dty_q <= '{default: '0}; done_q <= 1'b0; abort_q <= 1'b0;
		end else begin
			st_q <= st_d; rq_q <= rq_d; tlb_q <= tlb_d; ph_q <= ph_d;
			pa_q <= pa_d; l1_q <= l1_d; hwd_q <= hwd_d;
			rdat_q <= rdat_d; rdo_q <= rdo_d; ctrl_q <= ctrl_d;
			ttb_q <= ttb_d; dom_q <= dom_d; far_q <= far_d;
			dfsr_q <= dfsr_d; ifsr_q <= ifsr_d; lock_q <= lock_d; ist_q <= ist_d; imsk_q <= imsk_d;
			bt_q <= bt_d; way_q <= way_d; tp_q <= tp_d; rr_q <= rr_d;
			val_q <= val_d; dty_q <= dty_d; done_q <= done_d; abort_q <= abort_d;
		end
	end
	always_ff @(posedge clock_in) begin
		if (tw_en) begin
			tag_mem[cs][way_q][set] <= rq_q.addr[31:12];
		end
		if (dw_en) begin
			dat_mem[cs][st_q == mwfc_pkg::ST_RFIL ? way_q : hway][dw_idx] <= dw_dat;
		end
	end
	// ************************************************************
	// Outputs
	// ************************************************************
	assign core_busy_out = st_q != mwfc_pkg::ST_IDLE;
	assign core_done_out = done_q;
	assign core_abort_out = abort_q;
	assign core_rdata_out = rdat_q;
	assign reg_rdata_out = rdo_q;
	assign irq_out = |(ist_q & imsk_q);
	assign htrans_out = (!ph_q && st_q != mwfc_pkg::ST_IDLE && st_q != mwfc_pkg::ST_XLAT) ?
		mwfc_pkg::HT_NSEQ : mwfc_pkg::HT_IDLE;
	assign haddr_out = pa_q;
	assign hwrite_out = st_q == mwfc_pkg::ST_WBUF;
	assign hsize_out = st_q == mwfc_pkg::ST_WBUF ? {1'b0, rq_q.size} : mwfc_pkg::HS_WORD;
	assign hwdata_out = hwd_q;
	// ************************************************************
	// Assertions
	// ************************************************************
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (!rst_b_in);
	property p_walk_fill;
		st_q == mwfc_pkg::ST_WLK2 && ph_q && hready_in && hrdata_in[1:0] != mwfc_pkg::D_FLT
			|=> st_q == mwfc_pkg::ST_XLAT && thit;
	endproperty
	a_walk_fill: assert property (p_walk_fill) else $error("walk result not in TLB");
	property p_section_one;
		st_q == mwfc_pkg::ST_WLK1 && ph_q && hready_in && hrdata_in[1:0] == mwfc_pkg::D_SEC
			|=> st_q == mwfc_pkg::ST_XLAT;
	endproperty
	a_section_one: assert property (p_section_one) else $error("section needed second fetch");
	property p_no_ifetch_align;
		ifsr_q[3:0] != mwfc_pkg::F_ALN || $stable(ifsr_q);
	endproperty
	a_no_ifetch_align: assert property (p_no_ifetch_align) else $error("alignment on fetch");
	property p_abort;
		st_q == mwfc_pkg::ST_XLAT && flt |=> core_done_out && core_abort_out && !core_busy_out;
	endproperty
	a_abort: assert property (p_abort) else $error("fault not aborted");
	property p_far;
		st_q == mwfc_pkg::ST_XLAT && flt && rq_q.data
			|=> far_q == $past(rq_q.addr) && dfsr_q == {$past(fdom), $past(fcode)};
	endproperty
	a_far: assert property (p_far) else $error("data fault not captured");
	property p_crit;
		st_q == mwfc_pkg::ST_RFIL && ph_q && hready_in && bt_q == 3'h0
			|=> core_done_out && core_rdata_out == $past(hrdata_in) && core_busy_out;
	endproperty
	a_crit: assert property (p_crit) else $error("critical word not first");
	property p_late_valid;
		st_q == mwfc_pkg::ST_RFIL |-> chit == 4'h0;
	endproperty
	a_late_valid: assert property (p_late_valid) else $error("line valid before refill end");
	property p_flat;
		st_q == mwfc_pkg::ST_XLAT && !ctrl_q[mwfc_pkg::C_MMU] && !flt |=> pa_q == $past(rq_q.addr);
	endproperty
	a_flat: assert property (p_flat) else $error("flat mapping broken");
	property p_ic_off;
		st_q == mwfc_pkg::ST_XLAT && !rq_q.data && !ctrl_q[mwfc_pkg::C_IC] |=> st_q != mwfc_pkg::ST_RFIL;
	endproperty
	a_ic_off: assert property (p_ic_off) else $error("disabled cache refilled");
	property p_lock;
		st_q == mwfc_pkg::ST_XLAT && st_d == mwfc_pkg::ST_RFIL |-> !lk[vict] ##1 way_q == $past(vict);
	endproperty
	a_lock: assert property (p_lock) else $error("locked way chosen");
endmodule : mwfc_top

//--- dv/mwfc_ahb_mem.sv
// AHB memory model for the far side of the walker and cache block
`timescale 1ns/100ps
module mwfc_ahb_mem (
	input wire logic clock_in,
	input wire logic rst_b_in,
	input wire logic slow_in,
	input wire logic [1:0] htrans_in,
	input wire logic [31:0] haddr_in,
	input wire logic hwrite_in,
	input wire logic [31:0] hwdata_in,
	output logic hready_out,
	output logic [31:0] hrdata_out
);
	logic [31:0] mem [0:1023];
	logic dp_q;
	logic wr_q;
	logic [9:0] a_q;
	logic [31:0] junk_q;
	initial begin
		for (int i = 0; i < 1024; i++) begin
			mem[i] = {20'ha5000, i[9:0], 2'h0};
		end
	end
	// Outside a read data phase the bus changes every cycle, so no stale word can pass
	assign hrdata_out = (dp_q && hready_out && !wr_q) ? mem[a_q] : junk_q;
	always @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			dp_q <= 1'h0;
			wr_q <= 1'h0;
			a_q <= 10'h0;
			hready_out <= 1'h1;
			junk_q <= 32'h0;
		end else begin
			junk_q <= junk_q + 32'h1357_9bdf;
			if (dp_q && hready_out && wr_q) begin
				mem[a_q] <= hwdata_in;
			end
			if (hready_out && htrans_in == 2'h2) begin
				dp_q <= 1'h1;
				wr_q <= hwrite_in;
				a_q <= haddr_in[11:2];
				hready_out <= !slow_in;
			end else if (dp_q && !hready_out) begin
				hready_out <= 1'h1;
			end else if (dp_q) begin
				dp_q <= 1'h0;
			end
		end
	end
endmodule : mwfc_ahb_mem

//--- dv/tb_mwfc_top.sv
// Self-checking bench for the walker, fault capture and cache block
`timescale 1ns/100ps
module tb_mwfc_top;
	logic clock_in = 1'h0;
	logic rst_b_in = 1'h0;
	logic core_req_vld_in = 1'h0;
	mwfc_pkg::mwfc_req_t core_req_in = '0;
	logic core_busy_out, core_done_out, core_abort_out, hwrite_out, hready_in, irq_out;
	logic [31:0] core_rdata_out, reg_rdata_out, haddr_out, hwdata_out, hrdata_in;
	logic [5:0] reg_addr_in = 6'h0;
	logic [31:0] reg_wdata_in = 32'h0;
	logic reg_wr_in = 1'h0;
	logic reg_rd_in = 1'h0;
	logic slow = 1'h0;
	logic [1:0] htrans_out;
	logic [2:0] hsize_out;
	logic [5:0] ra [0:4] = '{mwfc_pkg::A_CTRL, mwfc_pkg::A_DFSR, mwfc_pkg::A_IFSR, mwfc_pkg::A_LOCK, 6'h3c};
	int n_errors = 0;
	int n_compared = 0;
	int cyc_cnt = 0;
	int cyc;
	mwfc_top mwfc_top_inst (.clock_in(clock_in), .rst_b_in(rst_b_in), .core_req_vld_in(core_req_vld_in),
		.core_req_in(core_req_in), .core_busy_out(core_busy_out), .core_done_out(core_done_out),
		.core_abort_out(core_abort_out), .core_rdata_out(core_rdata_out), .reg_addr_in(reg_addr_in),
		.reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
		.htrans_out(htrans_out), .haddr_out(haddr_out), .hwrite_out(hwrite_out), .hsize_out(hsize_out),
		.hwdata_out(hwdata_out), .hready_in(hready_in), .hrdata_in(hrdata_in), .irq_out(irq_out));
	mwfc_ahb_mem mwfc_ahb_mem_inst (.clock_in(clock_in), .rst_b_in(rst_b_in), .slow_in(slow),
		.htrans_in(htrans_out), .haddr_in(haddr_out), .hwrite_in(hwrite_out), .hwdata_in(hwdata_out),
		.hready_out(hready_in), .hrdata_out(hrdata_in));
	// ************************************************************
	// Clock, timeout and helpers
	// ************************************************************
	initial begin
		forever #20 clock_in = ~clock_in;
	end
	always @(posedge clock_in) begin
		cyc_cnt <= cyc_cnt + 1;
		if (cyc_cnt == 20000) begin
			n_errors++;
			end_of_test();
		end
	end
	// Every bench access is a word, so each bus transfer must be word sized
	always @(posedge clock_in) begin
		if (rst_b_in && htrans_out == 2'h2 && hsize_out !== 3'h2) begin
			n_errors++;
			$display("Error at %0t: bus size %h", $time, hsize_out);
		end
	end
	function automatic logic [31:0] pat(input logic [31:0] a);
		return {20'ha5000, a[11:2], 2'h0};
	endfunction : pat
	task automatic end_of_test();
		$display("Compared %0d, errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : end_of_test
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("Error at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic rd(input logic [5:0] a, input logic [31:0] exp);
		@(posedge clock_in);
		reg_rd_in <= 1'h1;
		reg_addr_in <= a;
		@(posedge clock_in);
		reg_rd_in <= 1'h0;
		#1 chk(reg_rdata_out, exp);
	endtask : rd
	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		@(posedge clock_in);
		reg_wr_in <= 1'h1;
		reg_addr_in <= a;
		reg_wdata_in <= d;
		@(posedge clock_in);
		reg_wr_in <= 1'h0;
	endtask : wr
	task automatic idle();
		for (int k = 0; k < 100 && core_busy_out !== 1'h0; k++) begin
			@(posedge clock_in);
			#1;
		end
	endtask : idle
	// Refill keeps the block busy after the critical word, so each access first waits for idle
	task automatic acc(input logic d, input logic w, input logic [31:0] a, input logic [31:0] wd,
			input logic ab, input logic ck, input logic [31:0] ex, output int n);
		idle();
		@(posedge clock_in);
		core_req_vld_in <= 1'h1;
		core_req_in <= '{data: d, write: w, priv: 1'h1, size: 2'h2, addr: a, wdata: wd};
		@(posedge clock_in);
		core_req_vld_in <= 1'h0;
		for (n = 0; n < 200 && core_done_out !== 1'h1; n++) begin
			@(posedge clock_in);
			#1;
		end
		chk({31'h0, core_done_out}, 32'h1);
		chk({31'h0, core_abort_out}, {31'h0, ab});
		if (ck) begin
			chk(core_rdata_out, ex);
		end
	endtask : acc
	// ************************************************************
	// Test sequence
	// ************************************************************
	initial begin
		repeat (10) @(posedge clock_in);
		rst_b_in <= 1'h1;
		foreach (ra[i]) rd(ra[i], mwfc_pkg::RST0);
		wr(mwfc_pkg::A_CTRL, 32'h1000);
		wr(mwfc_pkg::A_IMSK, 32'h4);
		acc(1'h0, 1'h0, 32'h154, 32'h0, 1'h0, 1'h1, pat(32'h154), cyc);
		idle();
		rd(mwfc_pkg::A_IST, 32'h4);
		chk({31'h0, irq_out}, 32'h1);
		acc(1'h0, 1'h0, 32'h150, 32'h0, 1'h0, 1'h1, pat(32'h150), cyc);
		chk(32'(cyc), 32'h1);
		mwfc_ahb_mem_inst.mem[84] = 32'h0bad_0001;
		wr(mwfc_pkg::A_CTRL, 32'h0);
		acc(1'h0, 1'h0, 32'h150, 32'h0, 1'h0, 1'h1, 32'h0bad_0001, cyc);
		acc(1'h1, 1'h1, 32'h200, 32'h1234_5678, 1'h0, 1'h0, 32'h0, cyc);
		idle();
		chk(mwfc_ahb_mem_inst.mem[128], 32'h1234_5678);
		wr(mwfc_pkg::A_IST, 32'h7);
		rd(mwfc_pkg::A_IST, 32'h0);
		chk({31'h0, irq_out}, 32'h0);
		// Tables: section at index 1, fault at 2, coarse table at 0x400 with a small page, no-access section at 4
		mwfc_ahb_mem_inst.mem[1] = 32'h0000_0c02;
		mwfc_ahb_mem_inst.mem[2] = 32'h0;
		mwfc_ahb_mem_inst.mem[3] = 32'h0000_0401;
		mwfc_ahb_mem_inst.mem[257] = 32'h0000_0032;
		mwfc_ahb_mem_inst.mem[4] = 32'h0000_0002;
		wr(mwfc_pkg::A_TTB, 32'h0);
		wr(mwfc_pkg::A_DOM, 32'h1);
		wr(mwfc_pkg::A_CTRL, 32'h1);
		acc(1'h1, 1'h0, 32'h0010_0040, 32'h0, 1'h0, 1'h1, pat(32'h40), cyc);
		acc(1'h1, 1'h0, 32'h0020_0000, 32'h0, 1'h1, 1'h0, 32'h0, cyc);
		rd(mwfc_pkg::A_DFSR, {28'h0, mwfc_pkg::F_TRS});
		rd(mwfc_pkg::A_FAR, 32'h0020_0000);
		rd(mwfc_pkg::A_IST, 32'h1);
		wr(mwfc_pkg::A_DOM, 32'h0);
		acc(1'h1, 1'h0, 32'h0010_0000, 32'h0, 1'h1, 1'h0, 32'h0, cyc);
		rd(mwfc_pkg::A_DFSR, {28'h0, mwfc_pkg::F_DMS});
		wr(mwfc_pkg::A_DOM, 32'h1);
		wr(mwfc_pkg::A_CTRL, 32'h3);
		acc(1'h1, 1'h0, 32'h0010_0001, 32'h0, 1'h1, 1'h0, 32'h0, cyc);
		rd(mwfc_pkg::A_DFSR, {28'h0, mwfc_pkg::F_ALN});
		rd(mwfc_pkg::A_FAR, 32'h0010_0001);
		acc(1'h0, 1'h0, 32'h0010_0001, 32'h0, 1'h0, 1'h0, 32'h0, cyc);
		acc(1'h0, 1'h0, 32'h0020_0000, 32'h0, 1'h1, 1'h0, 32'h0, cyc);
		rd(mwfc_pkg::A_IFSR, {28'h0, mwfc_pkg::F_TRS});
		rd(mwfc_pkg::A_DFSR, {28'h0, mwfc_pkg::F_ALN});
		slow <= 1'h1;
		acc(1'h1, 1'h0, 32'h0030_1080, 32'h0, 1'h0, 1'h1, pat(32'h80), cyc);
		acc(1'h1, 1'h0, 32'h0040_0000, 32'h0, 1'h1, 1'h0, 32'h0, cyc);
		rd(mwfc_pkg::A_DFSR, {28'h0, mwfc_pkg::F_PMS});
		end_of_test();
	end
endmodule : tb_mwfc_top
